// ---- logic/bcbc_pkg.sv ----
// package: shared types and constants of the backplane cpu bus control block
package bcbc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] IR_RESET = 8'h00;
   localparam logic [7:0] RST_VECTOR = 8'hFF; // restart opcode fed during interrupt ack

   // machine cycle sequencer states, gray from IDLE through T1, T2 and TW to T3
   typedef enum logic [2:0] {
      BCBC_IDLE = 3'b000,
      BCBC_T1 = 3'b001,
      BCBC_T2 = 3'b011,
      BCBC_TW = 3'b010,
      BCBC_T3 = 3'b110,
      BCBC_HOLD = 3'b111,
      BCBC_HALT = 3'b101
   } bcbc_state_t;

   // cycle kinds requested by the core side
   typedef enum logic [2:0] {
      BCBC_FETCH = 3'h0,
      BCBC_MRD = 3'h1,
      BCBC_MWR = 3'h2,
      BCBC_SRD = 3'h3,
      BCBC_SWR = 3'h4,
      BCBC_INP = 3'h5,
      BCBC_OUT = 3'h6,
      BCBC_HLT = 3'h7
   } bcbc_kind_t;

   // status lines latched at sync
   typedef struct packed {
      logic inta;
      logic wo;
      logic stack;
      logic inp;
      logic out;
      logic memr;
   } bcbc_status_t;

   // strobes on the backplane
   typedef struct packed {
      logic sync;
      logic dbin;
      logic wr;
      logic mwrite;
   } bcbc_strobe_t;
endpackage : bcbc_pkg

// ---- logic/bcbc_sync3.sv ----
// three-flop synchroniser with agreement filter for one backplane input
`timescale 1ns/1ps
`default_nettype none
module bcbc_sync3 (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } bcbc_sync_t;
   bcbc_sync_t st;
   bcbc_sync_t next_st;

   // a change counts only once stages two and three agree; s1 feeds s2 alone
   always_comb begin
      next_st = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.q = st.s3;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign q_o = st.q;
endmodule : bcbc_sync3
`default_nettype wire

// ---- logic/bcbc_top.sv ----
// backplane cpu bus control: machine cycle sequencer, strobes, status, hold, interrupt
`timescale 1ns/1ps
`default_nettype none
module bcbc_top (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // core side request
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire bcbc_pkg::bcbc_kind_t REQ_KIND_I,
   input wire logic [15:0] REQ_ADDR_I,
   input wire logic [7:0] REQ_WDATA_I,
   input wire logic REQ_LAST_I,
   input wire logic INTE_I,
   output logic DONE_O,
   output logic [7:0] RDATA_O,
   output logic INT_TAKEN_O,
   output logic [15:0] PC_O,
   output logic [7:0] IR_O,
   // backplane pins
   input wire logic PRDY_I,
   input wire logic PINT_N_I,
   input wire logic PHOLD_N_I,
   input wire logic [7:0] DI_I,
   output logic [15:0] ADDR_O,
   output logic ADDR_OE_O,
   output logic [7:0] DO_O,
   output logic DO_OE_O,
   output bcbc_pkg::bcbc_strobe_t STB_O,
   output bcbc_pkg::bcbc_status_t STAT_O,
   output logic HLDA_O
);
   typedef struct packed {
      bcbc_pkg::bcbc_state_t state;
      logic [15:0] addr;
      logic [7:0] dout;
      bcbc_pkg::bcbc_kind_t kind;
      logic last;
      logic ack;
      logic [7:0] rdata;
      logic done;
      logic taken;
      logic [15:0] pc;
      logic [7:0] ir;
      bcbc_pkg::bcbc_status_t stat;
      bcbc_pkg::bcbc_strobe_t stb;
   } bcbc_st_t;
   bcbc_st_t st;
   bcbc_st_t next_st;
   logic rdy;
   logic int_n;
   logic hold_n;
   logic int_ok;
   logic int_req;
   logic hold_req;

   // backplane ready, interrupt and hold come from other boards, so each passes the synchroniser; DI_I does not
   bcbc_sync3 u_rdy (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(PRDY_I), .q_o(rdy));
   // active-low pins enter inverted so a cleared filter reads idle, not a false request
   bcbc_sync3 u_int (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(!PINT_N_I), .q_o(int_req));
   bcbc_sync3 u_hld (.clk_i(CLK_I), .rstn_i(RSTN_I), .d_i(!PHOLD_N_I), .q_o(hold_req));
   assign int_n = !int_req;
   assign hold_n = !hold_req;

   // interrupt honoured only when enabled and not in hold
   assign int_ok = !int_n && INTE_I && hold_n;

   // sequencer: T1 sync, T2 strobes, TW waits, T3 completes
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.taken = 1'b0;
      next_st.stb.sync = 1'b0;
      case (st.state)
         bcbc_pkg::BCBC_IDLE: begin
            if (!hold_n) begin
               next_st.state = bcbc_pkg::BCBC_HOLD;
            end else if (REQ_VALID_I && !st.ack) begin
               next_st.addr = REQ_ADDR_I;
               next_st.dout = REQ_WDATA_I;
               next_st.kind = REQ_KIND_I;
               next_st.last = REQ_LAST_I;
               next_st.ack = 1'b0;
               next_st.state = bcbc_pkg::BCBC_T1;
               next_st.stb.sync = 1'b1;
               // status valid from sync onward
               next_st.stat.wo = REQ_KIND_I == bcbc_pkg::BCBC_MWR
                  || REQ_KIND_I == bcbc_pkg::BCBC_SWR
                  || REQ_KIND_I == bcbc_pkg::BCBC_OUT;
               next_st.stat.stack = REQ_KIND_I == bcbc_pkg::BCBC_SRD
                  || REQ_KIND_I == bcbc_pkg::BCBC_SWR;
               next_st.stat.inp = REQ_KIND_I == bcbc_pkg::BCBC_INP;
               next_st.stat.out = REQ_KIND_I == bcbc_pkg::BCBC_OUT;
               next_st.stat.memr = REQ_KIND_I == bcbc_pkg::BCBC_FETCH
                  || REQ_KIND_I == bcbc_pkg::BCBC_MRD || REQ_KIND_I == bcbc_pkg::BCBC_SRD;
               next_st.stat.inta = 1'b0;
               if (REQ_KIND_I == bcbc_pkg::BCBC_FETCH) begin
                  next_st.pc = REQ_ADDR_I;
               end
            end
         end
         bcbc_pkg::BCBC_T1: begin
            next_st.state = bcbc_pkg::BCBC_T2;
            if (st.stat.wo) begin
               next_st.stb.wr = 1'b1;
               next_st.stb.mwrite = !st.stat.out;
            end else begin
               next_st.stb.dbin = 1'b1;
            end
         end
         bcbc_pkg::BCBC_T2, bcbc_pkg::BCBC_TW: begin
            // stretch while the slave holds ready low
            if (rdy) begin
               next_st.state = bcbc_pkg::BCBC_T3;
            end else begin
               next_st.state = bcbc_pkg::BCBC_TW;
            end
         end
         bcbc_pkg::BCBC_T3: begin
            next_st.stb.wr = 1'b0;
            next_st.stb.mwrite = 1'b0;
            next_st.stb.dbin = 1'b0;
            next_st.done = 1'b1;
            next_st.stat = '0;
            if (st.stat.inta) begin
               next_st.rdata = bcbc_pkg::RST_VECTOR;
               next_st.ir = bcbc_pkg::RST_VECTOR;
            end else begin
               next_st.rdata = DI_I;
               if (st.kind == bcbc_pkg::BCBC_FETCH) begin
                  next_st.ir = DI_I;
               end
            end
            if (st.kind == bcbc_pkg::BCBC_HLT) begin
               next_st.state = bcbc_pkg::BCBC_HALT;
            end else if (st.last && int_ok && !st.stat.inta) begin
               next_st.state = bcbc_pkg::BCBC_IDLE;
               next_st.ack = 1'b1;
            end else begin
               next_st.state = bcbc_pkg::BCBC_IDLE;
            end
         end
         bcbc_pkg::BCBC_HOLD: begin
            if (hold_n) begin
               next_st.state = bcbc_pkg::BCBC_IDLE;
            end
         end
         bcbc_pkg::BCBC_HALT: begin
            // halted: interrupt sampled any time
            if (int_ok) begin
               next_st.ack = 1'b1;
               next_st.state = bcbc_pkg::BCBC_IDLE;
            end
         end
         default: begin
            next_st.state = bcbc_pkg::BCBC_IDLE;
         end
      endcase
      // acknowledge cycle runs ahead of any core request
      if (st.ack && st.state == bcbc_pkg::BCBC_IDLE && hold_n) begin
         next_st.ack = 1'b0;
         next_st.taken = 1'b1;
         next_st.kind = bcbc_pkg::BCBC_FETCH;
         next_st.last = 1'b0;
         next_st.state = bcbc_pkg::BCBC_T1;
         next_st.stb.sync = 1'b1;
         next_st.stat = '0;
         next_st.stat.inta = 1'b1;
         next_st.stat.memr = 1'b0;
      end
   end

   // synchronous reset clears pc and ir, held as long as reset stays low
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         st <= '0;
         st.pc <= bcbc_pkg::PC_RESET;
         st.ir <= bcbc_pkg::IR_RESET;
      end else begin
         st <= next_st;
      end
   end

   // a core request is taken only in idle with no ack pending and no hold
   assign REQ_READY_O = st.state == bcbc_pkg::BCBC_IDLE && hold_n && !st.ack;
   assign DONE_O = st.done;
   assign RDATA_O = st.rdata;
   assign INT_TAKEN_O = st.taken;
   assign PC_O = st.pc;
   assign IR_O = st.ir;
   assign ADDR_O = st.addr;
   // buses float in hold so another master can drive them
   assign ADDR_OE_O = st.state != bcbc_pkg::BCBC_HOLD;
   assign HLDA_O = st.state == bcbc_pkg::BCBC_HOLD;
   assign DO_O = st.dout;
   assign DO_OE_O = st.stat.wo && st.state != bcbc_pkg::BCBC_HOLD;
   assign STB_O = st.stb;
   assign STAT_O = st.stat;

   // write data stays fixed while the write strobe is high
   AST_WR_DATA_STABLE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stb.wr && $past(st.stb.wr) |-> $stable(st.dout))
      else $error("data moved under write strobe");
   AST_MWRITE_WITH_WR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stb.mwrite |-> st.stb.wr && st.stat.wo && !st.stat.out)
      else $error("memory write without write cycle");
   AST_SYNC_STARTS_T1: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stb.sync |-> st.state == bcbc_pkg::BCBC_T1 ##1 !st.stb.sync)
      else $error("sync not a one cycle pulse at cycle start");
   AST_WAIT_ON_NOT_READY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (st.state == bcbc_pkg::BCBC_T2 || st.state == bcbc_pkg::BCBC_TW) && !rdy
      |=> st.state == bcbc_pkg::BCBC_TW)
      else $error("no wait state while not ready");
   AST_NO_INT_IN_HOLD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      (!INTE_I || !hold_n) && !st.ack |=> !st.ack)
      else $error("interrupt honoured while masked or held");
   AST_INT_AT_END: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $rose(st.ack) |-> $past(st.state) == bcbc_pkg::BCBC_T3
      || $past(st.state) == bcbc_pkg::BCBC_HALT)
      else $error("interrupt taken mid instruction");
   AST_HOLD_RELEASE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.state == bcbc_pkg::BCBC_HOLD |-> !ADDR_OE_O && !DO_OE_O && HLDA_O)
      else $error("buses driven in hold");
   AST_RESET_CLEARS: assert property (@(posedge CLK_I)
      // checked at release: state before the first reset edge is still unknown
      $rose(RSTN_I) |-> st.pc == bcbc_pkg::PC_RESET && st.ir == bcbc_pkg::IR_RESET)
      else $error("pc or ir not cleared by reset");
   AST_DBIN_ON_READ: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stb.dbin |-> !st.stat.wo ##0 !st.stb.wr)
      else $error("dbin on a write cycle");
   AST_STAT_HELD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.state == bcbc_pkg::BCBC_T2 |-> $stable(st.stat))
      else $error("status changed inside a cycle");
   AST_INTA_CYCLE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.taken |-> st.stat.inta && st.stb.sync)
      else $error("ack cycle without inta status");
   AST_OUT_WO: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stat.out |-> st.stat.wo && !st.stat.inp)
      else $error("output status without write out");
   AST_STACK_KIND: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stat.stack |-> st.kind == bcbc_pkg::BCBC_SRD || st.kind == bcbc_pkg::BCBC_SWR)
      else $error("stack status on non stack cycle");
   AST_INP_KIND: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stat.inp |-> st.kind == bcbc_pkg::BCBC_INP && !st.stat.wo)
      else $error("input status on wrong cycle");
   AST_WO_KIND: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      st.stat.wo |-> st.kind inside {bcbc_pkg::BCBC_MWR, bcbc_pkg::BCBC_SWR, bcbc_pkg::BCBC_OUT})
      else $error("write out status on read cycle");
endmodule : bcbc_top
`default_nettype wire

// ---- verif/bcbc_partner.sv ----
// partner model: memory and io board answering the backplane strobes
`timescale 1ns/1ps
`default_nettype none
module bcbc_partner #(parameter int WAITS = 2) (
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] do_i,
   input wire bcbc_pkg::bcbc_strobe_t stb_i,
   output logic prdy_o,
   output logic [7:0] di_o
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   int wcnt;
   initial begin
      prdy_o = 1'b1;
      di_o = 8'h00;
      last = 8'h00;
      wcnt = 0;
      foreach (mem[k]) mem[k] = 8'h00;
   end
   // acts just after each edge; odd addresses get longer stretches
   always @(posedge clk_i) begin
      #1;
      if (stb_i.sync) begin
         wcnt = WAITS + 2 * addr_i[0];
      end else if (wcnt > 0) begin
         wcnt = wcnt - 1;
      end
      prdy_o = (wcnt == 0) && !stb_i.sync;
      if (stb_i.wr) begin
         mem[addr_i[7:0]] = do_i;
      end
      // released lines show the inverse, so a stale value never passes
      if (stb_i.dbin) begin
         di_o = mem[addr_i[7:0]];
         last = di_o;
      end else begin
         di_o = ~last;
      end
   end
endmodule : bcbc_partner
`default_nettype wire

// ---- verif/test_bcbc_top.sv ----
// self-checking bench for the backplane cpu bus control block
`timescale 1ns/1ps
`default_nettype none
module test_bcbc_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic valid = 1'b0;
   bcbc_pkg::bcbc_kind_t kind = bcbc_pkg::BCBC_FETCH;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic last = 1'b0;
   logic inte = 1'b0;
   logic pint_n = 1'b1;
   logic phold_n = 1'b1;
   logic ready, done, int_taken, prdy, hlda, addr_oe, do_oe;
   logic [7:0] rdata, ir, di, dout;
   logic [15:0] pc, abus;
   bcbc_pkg::bcbc_strobe_t stb;
   bcbc_pkg::bcbc_status_t stat, stat_seen, stat_sync;
   logic [3:0] stb_seen;
   logic hlda_seen, taken_seen;
   logic [7:0] rd_seen;
   logic [15:0] a_sync;
   int n_sync;
   int n_mismatch = 0;
   int total_checks = 0;
   always #10 clk = ~clk;
   bcbc_top i_bcbc_top (.CLK_I(clk), .RSTN_I(rstn), .REQ_VALID_I(valid), .REQ_READY_O(ready),
      .REQ_KIND_I(kind), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .REQ_LAST_I(last),
      .INTE_I(inte), .DONE_O(done), .RDATA_O(rdata), .INT_TAKEN_O(int_taken), .PC_O(pc),
      .IR_O(ir), .PRDY_I(prdy), .PINT_N_I(pint_n), .PHOLD_N_I(phold_n), .DI_I(di),
      .ADDR_O(abus), .ADDR_OE_O(addr_oe), .DO_O(dout), .DO_OE_O(do_oe), .STB_O(stb),
      .STAT_O(stat), .HLDA_O(hlda));
   bcbc_partner i_bcbc_partner (.clk_i(clk), .addr_i(abus), .do_i(dout), .stb_i(stb),
      .prdy_o(prdy), .di_o(di));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   // holds the request until an edge sees ready high
   task automatic issue(input bcbc_pkg::bcbc_kind_t k, input logic [15:0] a,
         input logic [7:0] d, input logic l);
      logic taken;
      taken = 1'b0;
      kind = k;
      addr = a;
      wdata = d;
      last = l;
      valid = 1'b1;
      for (int i = 0; i < 40 && !taken; i++) begin
         @(negedge clk);
         taken = (ready === 1'b1);
         tick();
      end
      valid = 1'b0;
      if (!taken) begin
         check("request taken", 16'h0000, 16'h0001);
         report_and_stop();
      end
   endtask : issue
   // gathers strobes and status of one machine cycle up to its done pulse
   task automatic gather(input logic [7:0] d);
      stb_seen = 4'h0;
      stat_seen = '0;
      stat_sync = '0;
      hlda_seen = 1'b0;
      taken_seen = 1'b0;
      a_sync = 16'h0000;
      n_sync = 0;
      for (int i = 0; i < 40 && done !== 1'b1; i++) begin
         @(negedge clk);
         stb_seen = stb_seen | stb;
         stat_seen = stat_seen | stat;
         hlda_seen = hlda_seen | hlda;
         if (stb.sync === 1'b1) begin
            n_sync++;
            stat_sync = stat;
            taken_seen = int_taken;
            a_sync = abus;
         end
         if (stb.wr === 1'b1) check("data under write", {do_oe, dout}, {1'b1, d});
      end
      rd_seen = rdata;
      if (done !== 1'b1) begin
         check("cycle done", 16'h0000, 16'h0001);
         report_and_stop();
      end
      check("sync pulses", 16'(n_sync), 16'h0001);
      check("status from sync", stat_sync, stat_seen);
      tick();
   endtask : gather
   task automatic cyc(input bcbc_pkg::bcbc_kind_t k, input logic [15:0] a,
         input logic [7:0] d, input logic [3:0] stb_exp, input logic [5:0] st_exp);
      issue(k, a, d, 1'b0);
      gather(d);
      check("address", a_sync, a);
      check("strobes", stb_seen, stb_exp);
      check("status", stat_seen, st_exp);
   endtask : cyc
   task automatic t_mem();
      // strobe order {sync,dbin,wr,mwrite}, status {inta,wo,stack,inp,out,memr}
      cyc(bcbc_pkg::BCBC_MWR, 16'h0010, 8'hA5, 4'hB, 6'h10);
      check("stored byte", i_bcbc_partner.mem[16], 8'hA5);
      cyc(bcbc_pkg::BCBC_MRD, 16'h0010, 8'h00, 4'hC, 6'h01);
      check("read data", rd_seen, 8'hA5);
      cyc(bcbc_pkg::BCBC_SWR, 16'h0021, 8'h3C, 4'hB, 6'h18);
      cyc(bcbc_pkg::BCBC_SRD, 16'h0021, 8'h00, 4'hC, 6'h09);
      check("stack read", rd_seen, 8'h3C);
      $display("test memory done");
   endtask : t_mem
   task automatic t_io();
      // output strobes wr alone, no memory write line
      cyc(bcbc_pkg::BCBC_OUT, 16'h0042, 8'h5A, 4'hA, 6'h12);
      cyc(bcbc_pkg::BCBC_INP, 16'h0042, 8'h00, 4'hC, 6'h04);
      check("input data", rd_seen, 8'h5A);
      $display("test io done");
   endtask : t_io
   task automatic no_int(input int n);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         seen = seen | (int_taken === 1'b1);
      end
      check("interrupt ignored", seen, 16'h0000);
      tick();
   endtask : no_int
   task automatic t_int();
      pint_n = 1'b0;
      issue(bcbc_pkg::BCBC_FETCH, 16'h0100, 8'h00, 1'b1);
      gather(8'h00);
      no_int(10);
      inte = 1'b1;
      issue(bcbc_pkg::BCBC_FETCH, 16'h0101, 8'h00, 1'b0);
      gather(8'h00);
      no_int(10);
      issue(bcbc_pkg::BCBC_FETCH, 16'h0102, 8'h00, 1'b1);
      gather(8'h00);
      gather(8'h00);
      check("ack status", stat_seen.inta, 1'b1);
      check("ack opcode", rd_seen, bcbc_pkg::RST_VECTOR);
      check("ack flagged", taken_seen, 1'b1);
      check("ir after ack", ir, bcbc_pkg::RST_VECTOR);
      // halted: the pending request is taken without an instruction end
      issue(bcbc_pkg::BCBC_HLT, 16'h0103, 8'h00, 1'b0);
      gather(8'h00);
      gather(8'h00);
      check("ack from halt", {taken_seen, stat_seen.inta}, 16'h0003);
      pint_n = 1'b1;
      inte = 1'b0;
      $display("test interrupt done");
   endtask : t_int
   // reset in mid-run must clear a program counter that has moved
   task automatic t_rst();
      check("pc before reset", pc, 16'h0102);
      rstn = 1'b0;
      repeat (3) tick();
      check("pc held in reset", pc, bcbc_pkg::PC_RESET);
      check("ir held in reset", ir, bcbc_pkg::IR_RESET);
      rstn = 1'b1;
      $display("test mid-run reset done");
   endtask : t_rst
   task automatic t_hold();
      int i;
      issue(bcbc_pkg::BCBC_MWR, 16'h0030, 8'h77, 1'b0);
      phold_n = 1'b0;
      gather(8'h77);
      check("no hold mid cycle", hlda_seen, 1'b0);
      for (i = 0; i < 20 && hlda !== 1'b1; i++) tick();
      if (hlda !== 1'b1) begin
         check("hold granted in time", 16'h0000, 16'h0001);
         report_and_stop();
      end
      check("hold granted", {hlda, addr_oe, do_oe, ready}, 16'h0008);
      phold_n = 1'b1;
      for (i = 0; i < 20 && hlda !== 1'b0; i++) tick();
      if (hlda !== 1'b0) begin
         check("hold left in time", 16'h0000, 16'h0001);
         report_and_stop();
      end
      cyc(bcbc_pkg::BCBC_MRD, 16'h0030, 8'h00, 4'hC, 6'h01);
      check("read after hold", rd_seen, 8'h77);
      $display("test hold done");
   endtask : t_hold
   initial begin
      repeat (20) tick();
      check("pc in reset", pc, bcbc_pkg::PC_RESET);
      check("ir in reset", ir, bcbc_pkg::IR_RESET);
      rstn = 1'b1;
      $display("test reset done");
      t_mem();
      t_io();
      t_int();
      t_rst();
      t_hold();
      report_and_stop();
   end
endmodule : test_bcbc_top
`default_nettype wire
